// ---- logic/auto_home_search_sequencer.sv ----
/*
  Auto home search sequencer for four axes with a plain register port.
  Assumes sensor pins arrive asynchronously and the pulse generator
  acknowledges each output pulse with a one-cycle pulse_done_i.
*/
// What this block does
// R01: Run four homing steps strictly in order
// R02: Steps 1,4 drive speed; 2,3 home speed
// R03: Disabled step is skipped to the next
// R04: Step 1 runs until near home, decelerates
// R05: Near home or limit first: go step 2
// R06: Step 2 stops immediately on home input
// R07: Home already active: back off first
// R08: Limit in step 2: reverse past home
// R09: Step 3 stops immediately on index input
// R10: Home-and-index bit needs both inputs
// R11: Index during step 3 clears actual position
// R12: Step 3 errors: index early, limit
// R13: Step 4 outputs exact programmed pulse count
// R14: Limit in step 4 flags error, ends
// R15: Position-clear bit clears both counters after
// R16: Host loads drive and home speeds
// R17: Mode command latches both words together
// R18: Even bits enable, odd bits direction
// R19: Host sets limit bit for limit homing
// R20: Host writes deviation clear bits zero
// R21: Completion with interrupt enabled sets end flag, interrupt low
// R22: Reset clears all mode bits
// R23: Host starts homing on selected axes
// R24: Stop command ends the homing sequence
// R25: Each axis sequences independently
module auto_home_search_sequencer
  import home_search_pkg::*;
(
  input  wire logic                                  core_clk_i,   // 50 MHz clock
  input  wire logic                                  sys_rst_i,    // Synchronous reset
  input  wire logic [home_search_pkg::ADDR_BITS-1:0] addr_i,       // Register byte address
  input  wire logic [31:0]                           wdata_i,      // Write data
  input  wire logic                                  wr_i,         // Write strobe
  input  wire logic                                  rd_i,         // Read strobe
  output logic      [31:0]                           rdata_o,      // Read data, next cycle
  input  wire home_search_pkg::axis_pins_t [3:0]     pins_i,       // Async sensor pins
  input  wire logic [3:0]                            decel_done_i, // Decelerating stop finished
  input  wire logic [3:0]                            pulse_done_i, // One output pulse sent
  output home_search_pkg::drive_req_t [3:0]          drive_o,      // Drive requests
  output logic      [3:0]                            busy_o,       // Axis homing
  output logic                                       int_n_o,      // Interrupt, low active
  output logic                                       int_n_oe_o    // Drives interrupt pin
);
  import home_search_pkg::*;

  // Whole module state in one struct
  typedef struct packed {
    axis_state_t [3:0] ax;
    logic [15:0]       lo_pend;   // Extension word awaiting command
    logic [15:0]       hi_pend;   // Step word awaiting command
    logic [15:0]       ext_mode;  // Latched extension mode word
    logic [15:0]       step_mode; // Latched homing step mode word
    logic [31:0]       pulses;    // Offset pulse count
    logic [31:0]       rdata;     // Read data register
    axis_pins_t [3:0]  sync1;     // First synchroniser stage
    axis_pins_t [3:0]  sync2;     // Second synchroniser stage
  } core_state_t;

  core_state_t st_reg;
  core_state_t st_next;

  // Enable bit of step n (1..4)
  function automatic logic step_en(input logic [15:0] m, input logic [2:0] n);
    step_en = m[2*(n-3'd1)];                               // R18
  endfunction : step_en

  // Direction bit of step n, 1 means minus
  function automatic logic step_dir(input logic [15:0] m, input logic [2:0] n);
    step_dir = m[2*(n-3'd1)+1];                            // R18
  endfunction : step_dir

  // Search-direction limit for a direction
  function automatic logic lim_of(input axis_pins_t p, input logic neg);
    lim_of = neg ? p.negative_overrun_limit : p.positive_overrun_limit;
  endfunction : lim_of

  // Limit error bit for a direction
  function automatic logic [7:0] lim_err(input logic neg);
    lim_err = 8'h00;
    lim_err[neg ? BIT_ERR_LMTN : BIT_ERR_LMTP] = 1'b1;     // R12
  endfunction : lim_err

  // Next-state logic
  always_comb begin
    logic       sel;
    logic       d;
    logic       lim;
    axis_pins_t p;
    st_next       = st_reg;
    sel           = 1'b0;
    d             = 1'b0;
    lim           = 1'b0;
    p             = '0;
    st_next.sync1 = pins_i;
    st_next.sync2 = st_reg.sync1;
    st_next.rdata = 32'h0000_0000;

    // Register writes
    if (wr_i) begin
      unique case (addr_i)
        OFS_DATA_LO: st_next.lo_pend = wdata_i[15:0];
        OFS_DATA_HI: st_next.hi_pend = wdata_i[15:0];
        OFS_PULSES:  st_next.pulses  = wdata_i;
        OFS_CMD: begin
          if (wdata_i[7:0] == CMD_EXT_MODE) begin
            // Both words latched in one operation
            st_next.ext_mode  = st_reg.lo_pend;            // R17
            st_next.step_mode = st_reg.hi_pend;            // R17
          end
        end
        default: ;                                         // Unmapped writes ignored
      endcase
    end

    // Per-axis sequencers
    for (int a = 0; a < NUM_AXES; a++) begin
      p   = st_reg.sync2[a];
      sel = wr_i && addr_i == OFS_CMD && wdata_i[8+a];     // Axis select bits 11:8
      d   = step_dir(st_reg.step_mode, st_reg.ax[a].step);
      lim = lim_of(p, d);

      // Index clears actual position during step 3
      if (st_reg.ax[a].state == S_STEP3 && p.encoder_index_input)
        st_next.ax[a].actual_pos = POS_RESET;              // R11
      else if (pulse_done_i[a] && drive_o[a].run)
        st_next.ax[a].actual_pos = st_reg.ax[a].actual_pos + (drive_o[a].dir_neg ? 32'hffff_ffff : 32'h1);
      if (pulse_done_i[a] && drive_o[a].run)
        st_next.ax[a].logical_pos = st_reg.ax[a].logical_pos + (drive_o[a].dir_neg ? 32'hffff_ffff : 32'h1);

      if (sel && wdata_i[7:0] == CMD_STAT_CLR)
        st_next.ax[a].err = 8'h00;

      unique case (st_reg.ax[a].state)
        S_IDLE: begin
          if (sel && wdata_i[7:0] == CMD_HOME_RUN) begin   // R23
            st_next.ax[a].state = S_ENTER;
            st_next.ax[a].step  = 3'd1;
            st_next.ax[a].busy  = 1'b1;
            st_next.ax[a].err   = 8'h00;
          end
        end
        S_ENTER: begin
          // Skip disabled steps, then apply entry checks in order
          if (st_reg.ax[a].step > 3'd4)
            st_next.ax[a].state = S_DONE;                  // R01
          else if (!step_en(st_reg.step_mode, st_reg.ax[a].step))
            st_next.ax[a].step = st_reg.ax[a].step + 3'd1; // R03
          else begin
            unique case (st_reg.ax[a].step)
              3'd1: if (p.near_home_input || lim)
                      st_next.ax[a].step = 3'd2;           // R05
                    else
                      st_next.ax[a].state = S_STEP1;
              3'd2: if (lim)
                      st_next.ax[a].state = S_S2_ON;       // R08
                    else if (p.home_input)
                      st_next.ax[a].state = S_S2_OFF;      // R07
                    else
                      st_next.ax[a].state = S_STEP2;
              3'd3: if (p.encoder_index_input) begin
                      st_next.ax[a].err[BIT_ERR_INDEX] = 1'b1; // R12
                      st_next.ax[a].state = S_DONE;
                    end else if (lim) begin
                      st_next.ax[a].err = st_reg.ax[a].err | lim_err(d); // R12
                      st_next.ax[a].state = S_DONE;
                    end else
                      st_next.ax[a].state = S_STEP3;
              default: if (lim) begin
                      st_next.ax[a].err = st_reg.ax[a].err | lim_err(d); // R14
                      st_next.ax[a].state = S_DONE;
                    end else begin
                      st_next.ax[a].pulses_left = st_reg.pulses;
                      st_next.ax[a].state = S_STEP4;
                    end
            endcase
          end
        end
        S_STEP1: begin
          if (p.near_home_input)
            st_next.ax[a].state = S_DECEL;                 // R04
          else if (lim) begin
            st_next.ax[a].state = S_ENTER;                 // R05
            st_next.ax[a].step  = 3'd2;
          end
        end
        S_DECEL: begin
          if (decel_done_i[a]) begin
            st_next.ax[a].state = S_ENTER;                 // R04
            st_next.ax[a].step  = 3'd2;
          end
        end
        S_S2_ON: begin
          if (p.home_input)
            st_next.ax[a].state = S_S2_OFF;                // R08
        end
        S_S2_OFF: begin
          if (!p.home_input)
            st_next.ax[a].state = S_STEP2;                 // R07
        end
        S_STEP2: begin
          if (lim)
            st_next.ax[a].state = S_S2_ON;                 // R08
          else if (p.home_input) begin
            st_next.ax[a].state = S_ENTER;                 // R06
            st_next.ax[a].step  = 3'd3;
          end
        end
        S_STEP3: begin
          if (lim) begin
            st_next.ax[a].err   = st_reg.ax[a].err | lim_err(d); // R12
            st_next.ax[a].state = S_DONE;
          end else if (p.encoder_index_input &&
                       (!st_reg.step_mode[BIT_HOME_AND_INDEX_STOP] || p.home_input)) begin // R10
            st_next.ax[a].state = S_ENTER;                 // R09
            st_next.ax[a].step  = 3'd4;
          end
        end
        S_STEP4: begin
          if (lim) begin
            st_next.ax[a].err   = st_reg.ax[a].err | lim_err(d); // R14
            st_next.ax[a].state = S_DONE;
          end else if (st_reg.ax[a].pulses_left == 32'h0) begin
            if (st_reg.step_mode[BIT_POST_OFFSET_POSITION_CLEAR]) begin
              st_next.ax[a].actual_pos  = POS_RESET;       // R15
              st_next.ax[a].logical_pos = POS_RESET;       // R15
            end
            st_next.ax[a].state = S_DONE;                  // R13
          end else if (pulse_done_i[a])
            st_next.ax[a].pulses_left = st_reg.ax[a].pulses_left - 32'h1; // R13
        end
        S_DONE: begin
          st_next.ax[a].state = S_IDLE;
          st_next.ax[a].step  = 3'd0;
          st_next.ax[a].busy  = 1'b0;
          if (st_reg.ext_mode[BIT_HOMING_INTERRUPT_ENABLE])
            st_next.ax[a].homing_end_flag = 1'b1;                    // R21
        end
        default: st_next.ax[a].state = S_IDLE;
      endcase

      // A stop command ends any running step
      if (sel && (wdata_i[7:0] == CMD_DEC_STOP || wdata_i[7:0] == CMD_IMM_STOP)
          && st_reg.ax[a].state != S_IDLE) begin
        st_next.ax[a].state = S_DONE;                      // R24
      end
    end

    // Register reads; reading interrupt status clears the end flag unless it is set now
    if (rd_i && addr_i >= OFS_AXIS_BASE) begin
      unique case (addr_i[1:0] == 2'b00 ? {addr_i[3:2], 2'b00} : 4'hf)
        4'h0: st_next.rdata = {24'h0, st_reg.ax[addr_i[5:4]-2'd1].err};
        4'h4: begin
          st_next.rdata = {23'h0, st_reg.ax[addr_i[5:4]-2'd1].homing_end_flag, 8'h00};
          if (!(st_reg.ax[addr_i[5:4]-2'd1].state == S_DONE && st_reg.ext_mode[BIT_HOMING_INTERRUPT_ENABLE]))
            st_next.ax[addr_i[5:4]-2'd1].homing_end_flag = 1'b0;     // R21
        end
        4'h8: st_next.rdata = st_reg.ax[addr_i[5:4]-2'd1].actual_pos;
        default: st_next.rdata = 32'h0000_0000;           // Unmapped reads zero
      endcase
    end
  end

  // State register; reset clears every mode bit of every axis
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_reg           <= '0;
      st_reg.ext_mode  <= MODE_RESET;                      // R22
      st_reg.step_mode <= MODE_RESET;                      // R22
      for (int a = 0; a < NUM_AXES; a++)
        st_reg.ax[a].state <= S_IDLE;                      // R25
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  always_comb begin
    int_n_oe_o = 1'b0;
    for (int a = 0; a < NUM_AXES; a++) begin
      busy_o[a]          = st_reg.ax[a].busy;
      drive_o[a].run     = st_reg.ax[a].state inside {S_STEP1, S_S2_ON, S_S2_OFF, S_STEP2, S_STEP3}
                           || (st_reg.ax[a].state == S_STEP4 && st_reg.ax[a].pulses_left != 32'h0);
      drive_o[a].dir_neg = step_dir(st_reg.step_mode, st_reg.ax[a].step)
                           ^ (st_reg.ax[a].state inside {S_S2_ON, S_S2_OFF}); // R07
      drive_o[a].slow    = st_reg.ax[a].step inside {3'd2, 3'd3};            // R02
      int_n_oe_o         = int_n_oe_o | st_reg.ax[a].homing_end_flag;                  // R21
    end
  end
  assign int_n_o = 1'b0;
  assign rdata_o = st_reg.rdata;

  // Completion with interrupt enabled raises the end flag
  property p_end_flag;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (st_reg.ax[0].state == S_DONE && st_reg.ext_mode[BIT_HOMING_INTERRUPT_ENABLE]) |=> st_reg.ax[0].homing_end_flag;
  endproperty
  a_end_flag: assert property (p_end_flag) else $error("end flag not set"); // R21

  // Slow speed only in steps 2 and 3
  property p_speed;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      drive_o[0].run |-> (drive_o[0].slow == !(st_reg.ax[0].state inside {S_STEP1, S_STEP4}));
  endproperty
  a_speed: assert property (p_speed) else $error("wrong speed select"); // R02

  // Stop command ends homing within two cycles
  property p_stop;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (wr_i && addr_i == OFS_CMD && wdata_i[8] && wdata_i[7:0] == CMD_IMM_STOP
       && st_reg.ax[0].state != S_IDLE) |-> ##2 !busy_o[0];
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not end homing"); // R24

  // A disabled step only advances the step count
  property p_skip;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (st_reg.ax[0].state == S_ENTER && st_reg.ax[0].step <= 3'd4
       && !step_en(st_reg.step_mode, st_reg.ax[0].step))
      |=> st_reg.ax[0].step == $past(st_reg.ax[0].step) + 3'd1;
  endproperty
  a_skip: assert property (p_skip) else $error("disabled step not skipped"); // R03

  // Index seen in step 3 zeroes the actual position
  property p_index_clear;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (st_reg.ax[0].state == S_STEP3 && st_reg.sync2[0].encoder_index_input)
      |=> st_reg.ax[0].actual_pos == POS_RESET;
  endproperty
  a_index_clear: assert property (p_index_clear) else $error("index did not clear position"); // R11

  // Offset move ends once the count is spent
  property p_step4_end;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (st_reg.ax[0].state == S_STEP4 && st_reg.ax[0].pulses_left == 32'h0)
      |=> st_reg.ax[0].state == S_DONE;
  endproperty
  a_step4_end: assert property (p_step4_end) else $error("offset move did not end"); // R13
endmodule : auto_home_search_sequencer

// ---- logic/home_search_pkg.sv ----
/*
  Shared constants and types for the per-axis auto home search sequencer.
  Assumes one 50 MHz clock and a synchronous active-high reset.
*/
package home_search_pkg;

  localparam int          NUM_AXES        = 4;             // Independent axes
  localparam int          AXIS_BITS       = 2;             // Axis select width
  localparam int          ADDR_BITS       = 6;             // Register address width

  // Register map, byte addresses; per-axis block of 16 bytes
  localparam logic [5:0]  OFS_CMD         = 6'h00;         // Command and axis select (write)
  localparam logic [5:0]  OFS_DATA_LO     = 6'h04;         // Extension low data word (write)
  localparam logic [5:0]  OFS_DATA_HI     = 6'h08;         // Homing step data word (write)
  localparam logic [5:0]  OFS_PULSES      = 6'h0c;         // Offset pulse count (write)
  localparam logic [5:0]  OFS_AXIS_BASE   = 6'h10;         // First per-axis status block
  localparam logic [5:0]  OFS_ERR_STAT    = 6'h00;         // Per-axis error status offset
  localparam logic [5:0]  OFS_INT_STAT    = 6'h04;         // Per-axis interrupt status offset
  localparam logic [5:0]  OFS_EP_LO       = 6'h08;         // Per-axis actual position offset

  // Command codes
  localparam logic [7:0]  CMD_EXT_MODE    = 8'h60;         // Latch both mode words
  localparam logic [7:0]  CMD_HOME_RUN    = 8'h62;         // Start homing
  localparam logic [7:0]  CMD_DEC_STOP    = 8'h26;         // Decelerating stop
  localparam logic [7:0]  CMD_IMM_STOP    = 8'h27;         // Immediate stop
  localparam logic [7:0]  CMD_STAT_CLR    = 8'h25;         // Completion status clear

  // Homing step mode word fields
  localparam int          BIT_POST_OFFSET_POSITION_CLEAR        = 8;             // Clear positions after offset move
  localparam int          BIT_HOME_AND_INDEX_STOP        = 9;             // Index stop needs home too
  localparam int          BIT_LIMIT       = 10;            // Limit-based homing
  // Extension mode word field
  localparam int          BIT_HOMING_INTERRUPT_ENABLE       = 5;             // Homing interrupt enable
  // Status bit positions
  localparam int          BIT_ERR_LMTP    = 2;             // Positive limit error
  localparam int          BIT_ERR_LMTN    = 3;             // Negative limit error
  localparam int          BIT_ERR_INDEX   = 7;             // Index active at step 3 start
  localparam int          BIT_HOMING_END_FLAG       = 8;             // Homing end flag

  localparam logic [15:0] MODE_RESET      = 16'h0000;      // Mode words at reset
  localparam logic [31:0] POS_RESET       = 32'h0000_0000; // Position counters at reset

  // Sequencer states, one-hot
  typedef enum logic [9:0] {
    S_IDLE    = 10'h001,  // Waiting for a run command
    S_STEP1   = 10'h002,  // Fast near-home search
    S_DECEL   = 10'h004,  // Decelerating stop after near home
    S_S2_OFF  = 10'h008,  // Reverse until home inactive
    S_S2_ON   = 10'h010,  // Reverse until home active (limit hit)
    S_STEP2   = 10'h020,  // Slow home search
    S_STEP3   = 10'h040,  // Slow index search
    S_STEP4   = 10'h080,  // Offset move
    S_DONE    = 10'h100,  // Completion bookkeeping
    S_ENTER   = 10'h200   // Step entry checks
  } seq_state_t;

  // Drive request toward the pulse generator
  typedef struct packed {
    logic        run;     // Drive pulses
    logic        dir_neg; // 1 means minus direction
    logic        slow;    // 1 home search speed, 0 drive speed
  } drive_req_t;

  // Sensor pins of one axis, all active high after logic setting
  typedef struct packed {
    logic        near_home_input;
    logic        home_input;
    logic        encoder_index_input;
    logic        positive_overrun_limit;
    logic        negative_overrun_limit;
  } axis_pins_t;

  // Per-axis sequencer state
  typedef struct packed {
    seq_state_t  state;
    logic [2:0]  step;          // Current step 1..4, 5 once a disabled step 4 is skipped, 0 idle
    logic [31:0] pulses_left;   // Remaining offset pulses
    logic [31:0] actual_pos;    // Actual position counter
    logic [31:0] logical_pos;   // Logical position counter
    logic [7:0]  err;           // Axis error status
    logic        homing_end_flag;         // Homing end flag
    logic        busy;          // Running
  } axis_state_t;

endpackage : home_search_pkg

// ---- tb/auto_home_search_sequencer_bench.sv ----
/*
  Self-checking bench for the home search sequencer.
  Assumes the motor model beside it and the register map of the package.
*/
module auto_home_search_sequencer_bench
  import home_search_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   core_clk_i, sys_rst_i, wr_i, rd_i;
  logic [5:0]             addr_i;
  logic [31:0]            wdata_i, rdata_o, d;
  axis_pins_t [3:0]       pins;
  drive_req_t [3:0]       drive_o;
  logic [3:0]             decel_done, pulse_done, busy_o;
  logic                   int_n_o, int_n_oe_o;
  logic                   seen_fast, seen_slow, seen_neg; // Axis 0 drive history
  int                     mismatches, comparisons, cyc;
  auto_home_search_sequencer u_auto_home_search_sequencer (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pins_i(pins),
    .decel_done_i(decel_done), .pulse_done_i(pulse_done), .drive_o(drive_o), .busy_o(busy_o),
    .int_n_o(int_n_o), .int_n_oe_o(int_n_oe_o));
  motor_axis_model u_motor_axis_model (.core_clk_i(core_clk_i), .drive_i(drive_o),
    .pulse_done_o(pulse_done), .decel_done_o(decel_done), .pins_o(pins));
  // 50 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  // Hang guard and axis 0 speed history
  always @(posedge core_clk_i) begin
    if (drive_o[0].run) begin
      if (drive_o[0].slow) seen_slow = 1'b1;
      else seen_fast = 1'b1;
      if (drive_o[0].dir_neg) seen_neg = 1'b1;
    end
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [31:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    @(negedge core_clk_i);
    v = rdata_o;
  endtask : rd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wait_idle(input int a);
    int n;
    n = 0;
    repeat (3) @(posedge core_clk_i);
    while (busy_o[a] !== 1'b0 && n < 3000) begin
      @(posedge core_clk_i);
      n++;
    end
    chk("busy", 32'h0, {31'h0, busy_o[a]});
  endtask : wait_idle
  // Latch both mode words, then start; deviation clear bits stay zero
  task automatic arm(input logic [3:0] sel, input logic [15:0] ext, input logic [15:0] st, input logic [31:0] p);
    wr(OFS_DATA_LO, {16'h0, ext});
    wr(OFS_DATA_HI, {16'h0, st});
    wr(OFS_PULSES, p);
    wr(OFS_CMD, {20'h0, sel, CMD_EXT_MODE});
    seen_fast = 1'b0;
    seen_slow = 1'b0;
    seen_neg  = 1'b0;
    wr(OFS_CMD, {20'h0, sel, CMD_HOME_RUN});
  endtask : arm
  task automatic run(input int a, input int p0, input logic [15:0] ext, input logic [15:0] st, input logic [31:0] p);
    u_motor_axis_model.place(a, p0);
    arm(4'(1 << a), ext, st, p);
    wait_idle(a);
  endtask : run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    {wr_i, rd_i, addr_i, wdata_i} = '0;
    mismatches = 0;
    comparisons = 0;
    cyc = 0;
    sys_rst_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    chk("busy rst", 32'h0, {28'h0, busy_o});
    chk("irq rst", 32'h0, {31'h0, int_n_oe_o});
    rd(OFS_AXIS_BASE + OFS_ERR_STAT, d);
    chk("err rst", 32'h0, d);
    rd(6'h1c, d);
    chk("unmapped", 32'h0, d);
    // Full four-step run with interrupt and position clear
    run(0, -60, 16'h0020, 16'h0155, 5);
    chk("fast seen", 32'h1, {31'h0, seen_fast});
    chk("slow seen", 32'h1, {31'h0, seen_slow});
    rd(OFS_AXIS_BASE + OFS_EP_LO, d);
    chk("pos clear", 32'h0, d);
    chk("irq on", 32'h1, {31'h0, int_n_oe_o});
    chk("irq level", 32'h0, {31'h0, int_n_o});
    rd(OFS_AXIS_BASE + OFS_INT_STAT, d);
    chk("end flag", 32'h1, {31'h0, d[BIT_HOMING_END_FLAG]});
    rd(OFS_AXIS_BASE + OFS_INT_STAT, d);
    chk("end flag clr", 32'h0, {31'h0, d[BIT_HOMING_END_FLAG]});
    chk("irq off", 32'h0, {31'h0, int_n_oe_o});
    // Offset move alone, both directions, disabled steps skipped
    for (int k = 0; k < 2; k++) begin
      run(0, 0, 16'h0, 16'h0040 | 16'(k << 7), 5);
      chk("offset", k ? 32'hffff_fffb : 32'h0000_0005, 32'(u_motor_axis_model.pos[0]));
      chk("offset slow", 32'h0, {31'h0, seen_slow});
    end
    // Home search starting on home, then from the limit
    run(0, 0, 16'h0, 16'h0004, 0);
    chk("backoff", 32'h1, {31'h0, seen_neg});
    chk("at home", 32'h1, {31'h0, pins[0].home_input});
    run(0, 120, 16'h0, 16'h0404, 0);
    chk("reverse", 32'h1, {31'h0, seen_neg});
    chk("at home 2", 32'h1, {31'h0, pins[0].home_input});
    // Index search errors and home-and-index condition
    run(0, 8, 16'h0, 16'h0010, 0);
    rd(OFS_AXIS_BASE + OFS_ERR_STAT, d);
    chk("index early", 32'h1, {31'h0, d[BIT_ERR_INDEX]});
    run(0, 120, 16'h0, 16'h0010, 0);
    rd(OFS_AXIS_BASE + OFS_ERR_STAT, d);
    chk("lim step3", 32'h04, d & 32'h84);
    run(0, 0, 16'h0, 16'h0210, 0);
    rd(OFS_AXIS_BASE + OFS_ERR_STAT, d);
    chk("and stop", 32'h04, d & 32'h84);
    run(0, 0, 16'h0, 16'h0010, 0);
    chk("index stop", 32'h1, {31'h0, u_motor_axis_model.pos[0] < 12});
    // Offset move blocked by the limit
    run(0, 120, 16'h0, 16'h0040, 5);
    rd(OFS_AXIS_BASE + OFS_ERR_STAT, d);
    chk("lim step4", 32'h04, d & 32'h0c);
    chk("no move", 32'h0000_0078, 32'(u_motor_axis_model.pos[0]));
    wr(OFS_CMD, {20'h0, 4'h1, CMD_STAT_CLR});
    rd(OFS_AXIS_BASE + OFS_ERR_STAT, d);
    chk("err clr", 32'h0, d);
    // Stop commands in mid search, immediate then decelerating
    for (int k = 0; k < 2; k++) begin
      u_motor_axis_model.place(0, -90);
      arm(4'h1, 16'h0, 16'h0001, 0);
      repeat (20) @(posedge core_clk_i);
      wr(OFS_CMD, {20'h0, 4'h1, k ? CMD_DEC_STOP : CMD_IMM_STOP});
      wait_idle(0);
      chk("stopped far", 32'h1, {31'h0, u_motor_axis_model.pos[0] < -30});
    end
    // Axes run independently
    u_motor_axis_model.place(0, 0);
    run(1, 0, 16'h0, 16'h0040, 5);
    chk("axis0 still", 32'h0, 32'(u_motor_axis_model.pos[0]));
    chk("axis1 moved", 32'h5, 32'(u_motor_axis_model.pos[1]));
    wrap_up();
  end
endmodule : auto_home_search_sequencer_bench

// ---- tb/motor_axis_model.sv ----
/*
  Behavioural motor axis model: pulses move a position, sensors derive from it.
  Assumes drive requests from the sequencer; bench places axes by task call.
*/
module motor_axis_model
  import home_search_pkg::*;
(
  input  wire  logic                          core_clk_i,   // Bench clock
  input  wire  home_search_pkg::drive_req_t [3:0] drive_i,  // Drive requests
  output logic [3:0]                          pulse_done_o, // One pulse sent
  output logic [3:0]                          decel_done_o, // Decel stop done
  output home_search_pkg::axis_pins_t [3:0]   pins_o        // Sensor levels
);
  timeunit 1ns;
  timeprecision 1ns;
  int         pos [4];  // Axis position in pulses
  int         dcnt [4]; // Decel countdown
  logic [3:0] ph;       // Pulse phase, one pulse every two cycles
  logic [3:0] near_q;   // Last near-home level
  initial begin
    pulse_done_o = 4'h0;
    decel_done_o = 4'h0;
    ph           = 4'h0;
    near_q       = 4'h0;
    for (int a = 0; a < 4; a++) begin
      pos[a]  = 0;
      dcnt[a] = 0;
    end
  end
  // Sensor windows around home; limits far out
  always_comb begin
    for (int a = 0; a < 4; a++) begin
      pins_o[a].near_home_input        = pos[a] >= -30 && pos[a] <= 30;
      pins_o[a].home_input             = pos[a] >= -5 && pos[a] <= 5;
      pins_o[a].encoder_index_input    = pos[a] >= 8 && pos[a] <= 9;
      pins_o[a].positive_overrun_limit = pos[a] >= 100;
      pins_o[a].negative_overrun_limit = pos[a] <= -100;
    end
  end
  // Pulses at half rate; a fast drive meeting near home ends its decel later
  always @(posedge core_clk_i) begin
    for (int a = 0; a < 4; a++) begin
      pulse_done_o[a] <= 1'b0;
      decel_done_o[a] <= 1'b0;
      near_q[a]       <= pins_o[a].near_home_input;
      if (drive_i[a].run) begin
        ph[a] <= ~ph[a];
        if (ph[a]) begin
          pulse_done_o[a] <= 1'b1;
          pos[a]          <= pos[a] + (drive_i[a].dir_neg ? -1 : 1);
        end
      end else begin
        ph[a] <= 1'b0;
      end
      if (pins_o[a].near_home_input && !near_q[a] && drive_i[a].run && !drive_i[a].slow) begin
        dcnt[a] <= 3;
      end else if (dcnt[a] > 0) begin
        dcnt[a] <= dcnt[a] - 1;
        decel_done_o[a] <= (dcnt[a] == 1);
      end
    end
  end
  // Bench moves an axis by hand between runs
  task automatic place(input int a, input int p);
    pos[a] = p;
  endtask : place
endmodule : motor_axis_model
